// ===== core/acd_pkg.sv
// Constants and types of the serial command decoder
`default_nettype none

package acd_pkg;

  // ****************************************
  // Command codes
  // ****************************************
  localparam logic [7:0] OP_WAKEUP = 8'h00;
  localparam logic [7:0] OP_SLEEP = 8'h02;
  localparam logic [7:0] OP_SYNC = 8'h04;
  localparam logic [7:0] OP_RESET = 8'h06;
  localparam logic [7:0] OP_RDATA = 8'h12;
  localparam logic [7:0] OP_CONTINUOUS_READ_CMD = 8'h14;
  localparam logic [7:0] OP_STOP_CONTINUOUS_READ_CMD = 8'h16;
  localparam logic [3:0] OP_REGISTER_READ_CMD_HI = 4'h2;
  localparam logic [3:0] OP_REGISTER_WRITE_CMD_HI = 4'h4;
  localparam logic [7:0] OP_SYSTEM_OFFSET_CAL_CMD = 8'h60;
  localparam logic [7:0] OP_SYSTEM_GAIN_CAL_CMD = 8'h61;
  localparam logic [7:0] OP_INTERNAL_OFFSET_CAL_CMD = 8'h62;
  localparam logic [7:0] OP_NOP = 8'hff;
  localparam logic [7:0] OP_RESTRICTED = 8'hf1;

  // ****************************************
  // Data format and timing
  // ****************************************
  localparam int RAW_W = 26;
  localparam logic [23:0] CODE_POS_FS = 24'h7fffff;
  localparam logic [23:0] CODE_NEG_FS = 24'h800000;
  localparam int CLK_PERIOD_NS = 40;
  localparam int RST_HOLD_NS = 600000;
  localparam int RST_HOLD_CYC = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [6:0] IDLE_CONV = 7'h40;
  localparam logic [2:0] LAST_BIT = 3'h7;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SYNC2 = 3'b001,
    ST_RCNT = 3'b010,
    ST_WCNT = 3'b011,
    ST_WDATA = 3'b100,
    ST_ROUT = 3'b101,
    ST_HOLD = 3'b110
  } acd_state_type;

  // Match ignoring the don't-care low bit
  function automatic logic op_is(input logic [7:0] b, input logic [7:0] op);
    op_is = (b[7:1] == op[7:1]);
  endfunction : op_is

  // Clip a wide signed value to the 24-bit code range
  function automatic logic [23:0] sat24(input logic signed [RAW_W-1:0] v);
    if (v > $signed({{(RAW_W-24){1'b0}}, CODE_POS_FS})) sat24 = CODE_POS_FS;
    else if (v < $signed({{(RAW_W-24){1'b1}}, CODE_NEG_FS})) sat24 = CODE_NEG_FS;
    else sat24 = v[23:0];
  endfunction : sat24

endpackage : acd_pkg

`default_nettype wire

// ===== core/acd_link.sv
// Serial link end of the command decoder, on the serial clock
`default_nettype none

module acd_link
  import acd_pkg::*;
(
  input wire logic rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  input wire logic [23:0] tx_word,
  input wire logic tx_tgl,
  input wire logic tmo_clr,
  output logic dout,
  output logic dout_oe,
  output logic [7:0] rx_byte,
  output logic rx_tgl,
  output logic bit_tgl
);
  logic frame_rst;
  logic [2:0] cnt_ff;
  logic [6:0] sh_ff;
  logic ld_s1_ff;
  logic ld_s2_ff;
  logic ld_seen_ff;
  logic [22:0] osh_ff;

  // Timeout pulse comes from a core flop, so it is glitch free
  assign frame_rst = rst | cs_n | tmo_clr;
  assign dout_oe = ~cs_n;

  // ****************************************
  // Framing, cleared by deselect or idle timeout
  // ****************************************
  always_ff @(negedge sclk or posedge frame_rst) begin
    if (frame_rst) begin
      cnt_ff <= 3'h0;
      sh_ff <= 7'h00;
    end else begin
      cnt_ff <= cnt_ff + 3'h1;
      sh_ff <= {sh_ff[5:0], din};
    end
  end

  // ****************************************
  // Events toward the core
  // ****************************************
  always_ff @(negedge sclk or posedge rst) begin
    if (rst) begin
      bit_tgl <= 1'b0;
      rx_tgl <= 1'b0;
      rx_byte <= 8'h00;
    end else begin
      bit_tgl <= ~bit_tgl;
      if (cnt_ff == LAST_BIT && !cs_n) begin
        rx_byte <= {sh_ff, din};
        rx_tgl <= ~rx_tgl;
      end
    end
  end

  // ****************************************
  // Output shifter, loads only on byte boundaries
  // ****************************************
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      ld_s1_ff <= 1'b0;
      ld_s2_ff <= 1'b0;
      ld_seen_ff <= 1'b0;
      dout <= 1'b0;
      osh_ff <= 23'h000000;
    end else begin
      ld_s1_ff <= tx_tgl;
      ld_s2_ff <= ld_s1_ff;
      if (cnt_ff == 3'h0 && ld_s2_ff != ld_seen_ff) begin
        ld_seen_ff <= ld_s2_ff;
        dout <= tx_word[23];
        osh_ff <= tx_word[22:0];
      end else begin
        dout <= osh_ff[22];
        osh_ff <= {osh_ff[21:0], 1'b0};
      end
    end
  end

endmodule : acd_link

`default_nettype wire

// ===== core/acd_core.sv
// Command decoder core on the reference clock
`default_nettype none

module acd_core
  import acd_pkg::*;
#(
  parameter int unsigned RST_HOLD = RST_HOLD_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  input wire logic start,
  input wire logic conv_done,
  input wire logic signed [RAW_W-1:0] conv_raw,
  input wire logic [7:0] reg_rd_data,
  output logic dout,
  output logic dout_oe,
  output logic conversion_ready_n,
  output logic power_down,
  output logic cont_read_mode,
  output logic filter_reset,
  output logic cfg_reset,
  output logic sync_start,
  output logic system_offset_cal_cmd,
  output logic system_gain_cal_cmd,
  output logic internal_offset_cal_cmd,
  output logic [3:0] reg_addr,
  output logic reg_wr_en,
  output logic [7:0] reg_wr_data
);

  typedef struct packed {
    acd_state_type state;
    logic pd;
    logic sleep_pend;
    logic cont;
    logic pend_v;
    logic pend_val;
    logic rdy_n;
    logic load_tgl;
    logic fetch;
    logic tmo_p;
    logic wr_p;
    logic sync_p;
    logic [2:0] cal_p;
    logic [23:0] out_word;
    logic [23:0] latest;
    logic [3:0] addr;
    logic [3:0] left;
    logic [7:0] wr_data;
    logic [15:0] hold_cnt;
    logic [6:0] idle_cnt;
    logic start_s1;
    logic start_s2;
    logic cs_s1;
    logic cs_s2;
    logic byte_s1;
    logic byte_s2;
    logic byte_seen;
    logic bit_s1;
    logic bit_s2;
    logic bit_seen;
  } acd_core_type;

  acd_core_type r_ff;
  acd_core_type nxt_r;
  logic [7:0] rx_byte;
  logic rx_tgl;
  logic bit_tgl;
  logic byte_ev;
  logic bit_ev;
  logic cev;
  logic stopped;
  logic allowed;
  logic [7:0] b;

  // ****************************************
  // Serial clock domain
  // ****************************************
  acd_link u_link (
    .rst(rst),
    .sclk(sclk),
    .cs_n(cs_n),
    .din(din),
    .tx_word(r_ff.out_word),
    .tx_tgl(r_ff.load_tgl),
    .tmo_clr(r_ff.tmo_p),
    .dout(dout),
    .dout_oe(dout_oe),
    .rx_byte(rx_byte),
    .rx_tgl(rx_tgl),
    .bit_tgl(bit_tgl)
  );

  // ****************************************
  // Events and command filter
  // ****************************************
  assign byte_ev = r_ff.byte_s2 != r_ff.byte_seen;
  assign bit_ev = r_ff.bit_s2 != r_ff.bit_seen;
  assign cev = conv_done && !r_ff.pd;
  assign b = rx_byte;
  assign stopped = r_ff.pd || !r_ff.start_s2;
  assign allowed = !stopped || op_is(b, OP_RDATA) || op_is(b, OP_CONTINUOUS_READ_CMD)
                   || op_is(b, OP_STOP_CONTINUOUS_READ_CMD) || op_is(b, OP_WAKEUP) || b == OP_NOP;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    nxt_r = r_ff;
    nxt_r.start_s1 = start;
    nxt_r.start_s2 = r_ff.start_s1;
    nxt_r.cs_s1 = cs_n;
    nxt_r.cs_s2 = r_ff.cs_s1;
    nxt_r.byte_s1 = rx_tgl;
    nxt_r.byte_s2 = r_ff.byte_s1;
    nxt_r.byte_seen = r_ff.byte_s2;
    nxt_r.bit_s1 = bit_tgl;
    nxt_r.bit_s2 = r_ff.bit_s1;
    nxt_r.bit_seen = r_ff.bit_s2;
    nxt_r.wr_p = 1'b0;
    nxt_r.sync_p = 1'b0;
    nxt_r.cal_p = 3'h0;
    nxt_r.tmo_p = 1'b0;
    if (r_ff.wr_p) begin
      nxt_r.addr = r_ff.addr + 4'h1;
    end
    if (r_ff.fetch) begin
      nxt_r.out_word = {reg_rd_data, 16'h0000};
      nxt_r.load_tgl = ~r_ff.load_tgl;
      nxt_r.fetch = 1'b0;
    end
    if (bit_ev) begin
      nxt_r.rdy_n = 1'b1;
    end
    // New result; its ready edge wins over a lift
    if (cev) begin
      nxt_r.latest = sat24(conv_raw);
      nxt_r.rdy_n = 1'b0;
      if (r_ff.sleep_pend) begin
        nxt_r.pd = 1'b1;
        nxt_r.sleep_pend = 1'b0;
      end
      nxt_r.cont = r_ff.pend_v ? r_ff.pend_val : r_ff.cont;
      nxt_r.pend_v = 1'b0;
      if (nxt_r.cont && r_ff.state != ST_RCNT && r_ff.state != ST_ROUT) begin
        nxt_r.out_word = sat24(conv_raw);
        nxt_r.load_tgl = ~r_ff.load_tgl;
      end
    end
    // Framing watchdog while selected
    if (byte_ev || bit_ev || r_ff.cs_s2) begin
      nxt_r.idle_cnt = 7'h00;
    end else if (cev) begin
      if (r_ff.idle_cnt == IDLE_CONV - 7'h01) begin
        nxt_r.idle_cnt = 7'h00;
        nxt_r.tmo_p = 1'b1;
        if (r_ff.state != ST_HOLD) begin
          nxt_r.state = ST_IDLE;
        end
      end else begin
        nxt_r.idle_cnt = r_ff.idle_cnt + 7'h01;
      end
    end
    unique case (r_ff.state)
      ST_IDLE: begin
        if (byte_ev && allowed) begin
          if (op_is(b, OP_WAKEUP)) begin
            if (r_ff.start_s2) begin
              nxt_r.pd = 1'b0;
              nxt_r.sleep_pend = 1'b0;
            end
          end else if (op_is(b, OP_SLEEP)) begin
            nxt_r.sleep_pend = 1'b1;
          end else if (op_is(b, OP_SYNC)) begin
            nxt_r.state = ST_SYNC2;
          end else if (op_is(b, OP_RESET)) begin
            nxt_r.state = ST_HOLD;
            nxt_r.hold_cnt = 16'(RST_HOLD - 1);
            nxt_r.cont = 1'b1;
            nxt_r.pend_v = 1'b0;
            nxt_r.sleep_pend = 1'b0;
          end else if (op_is(b, OP_RDATA)) begin
            // A result finishing in this cycle is the latest one
            nxt_r.out_word = nxt_r.latest;
            nxt_r.load_tgl = ~r_ff.load_tgl;
          end else if (op_is(b, OP_CONTINUOUS_READ_CMD)) begin
            nxt_r.pend_v = 1'b1;
            nxt_r.pend_val = 1'b1;
          end else if (op_is(b, OP_STOP_CONTINUOUS_READ_CMD)) begin
            nxt_r.pend_v = 1'b1;
            nxt_r.pend_val = 1'b0;
          end else if (b[7:4] == OP_REGISTER_READ_CMD_HI) begin
            nxt_r.addr = b[3:0];
            nxt_r.state = ST_RCNT;
          end else if (b[7:4] == OP_REGISTER_WRITE_CMD_HI) begin
            nxt_r.addr = b[3:0];
            nxt_r.state = ST_WCNT;
          end else if (b == OP_SYSTEM_OFFSET_CAL_CMD) begin
            nxt_r.cal_p = 3'h1;
          end else if (b == OP_SYSTEM_GAIN_CAL_CMD) begin
            nxt_r.cal_p = 3'h2;
          end else if (b == OP_INTERNAL_OFFSET_CAL_CMD) begin
            nxt_r.cal_p = 3'h4;
          end
          // No-op, restricted and unknown codes fall through
        end
      end
      ST_SYNC2: begin
        if (byte_ev) begin
          nxt_r.state = ST_IDLE;
          nxt_r.sync_p = op_is(b, OP_SYNC) && !stopped;
        end
      end
      ST_RCNT: begin
        if (byte_ev) begin
          if (b[7:4] == 4'h0) begin
            nxt_r.left = b[3:0];
            nxt_r.fetch = 1'b1;
            nxt_r.state = ST_ROUT;
          end else begin
            nxt_r.state = ST_IDLE;
          end
        end
      end
      ST_ROUT: begin
        // Bytes clocked in during readout are ignored
        if (byte_ev) begin
          if (r_ff.left == 4'h0) begin
            nxt_r.state = ST_IDLE;
          end else begin
            nxt_r.left = r_ff.left - 4'h1;
            nxt_r.addr = r_ff.addr + 4'h1;
            nxt_r.fetch = 1'b1;
          end
        end
      end
      ST_WCNT: begin
        if (byte_ev) begin
          if (b[7:4] == 4'h0) begin
            nxt_r.left = b[3:0];
            nxt_r.state = ST_WDATA;
          end else begin
            nxt_r.state = ST_IDLE;
          end
        end
      end
      ST_WDATA: begin
        if (byte_ev) begin
          nxt_r.wr_p = 1'b1;
          nxt_r.wr_data = b;
          nxt_r.left = r_ff.left - 4'h1;
          if (r_ff.left == 4'h0) begin
            nxt_r.state = ST_IDLE;
          end
        end
      end
      ST_HOLD: begin
        if (r_ff.hold_cnt == 16'h0000) begin
          nxt_r.state = ST_IDLE;
        end else begin
          nxt_r.hold_cnt = r_ff.hold_cnt - 16'h0001;
        end
      end
      default: begin
        nxt_r.state = ST_IDLE;
      end
    endcase
    if (rst) begin
      nxt_r = '0;
      nxt_r.cont = 1'b1;
      nxt_r.rdy_n = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    r_ff <= nxt_r;
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign conversion_ready_n = r_ff.rdy_n;
  assign power_down = r_ff.pd;
  assign cont_read_mode = r_ff.cont;
  assign cfg_reset = r_ff.state == ST_HOLD;
  assign filter_reset = cfg_reset || r_ff.sync_p;
  assign sync_start = r_ff.sync_p;
  assign system_offset_cal_cmd = r_ff.cal_p[0];
  assign system_gain_cal_cmd = r_ff.cal_p[1];
  assign internal_offset_cal_cmd = r_ff.cal_p[2];
  assign reg_addr = r_ff.addr;
  assign reg_wr_en = r_ff.wr_p;
  assign reg_wr_data = r_ff.wr_data;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sat_high_a: assert property (cev && conv_raw > 26'sh07fffff |=> r_ff.latest == CODE_POS_FS)
    else $error("positive overrange not clipped");
  sat_low_a: assert property (cev && conv_raw < -26'sh0800000 |=> r_ff.latest == CODE_NEG_FS)
    else $error("negative overrange not clipped");
  sleep_wait_a: assert property ($rose(r_ff.pd) |-> $past(conv_done) && $past(r_ff.sleep_pend))
    else $error("power-down before conversion end");
  start_low_a: assert property (r_ff.pd && !r_ff.start_s2 |=> r_ff.pd)
    else $error("woke while start low");
  wake_a: assert property (byte_ev && r_ff.state == ST_IDLE && op_is(b, OP_WAKEUP) && r_ff.start_s2
                           |=> !r_ff.pd)
    else $error("wake-up ignored");
  stopped_a: assert property (byte_ev && r_ff.state == ST_IDLE && stopped && op_is(b, OP_SYNC)
                              |=> r_ff.state == ST_IDLE)
    else $error("command taken while stopped");
  hold_len_a: assert property ($rose(cfg_reset) |-> cfg_reset [*8] ##1 r_ff.hold_cnt == 16'(RST_HOLD - 9))
    else $error("soft reset hold too short");
  reset_mode_a: assert property ($past(rst) |-> r_ff.cont && r_ff.state == ST_IDLE)
    else $error("not continuous after reset");
  mode_late_a: assert property (r_ff.pend_v && !cev && !(byte_ev && op_is(b, OP_RESET)) |=> $stable(r_ff.cont))
    else $error("mode changed before ready");
  cont_load_a: assert property (cev && nxt_r.cont && r_ff.state == ST_IDLE
                                |=> r_ff.load_tgl != $past(r_ff.load_tgl) && r_ff.out_word == r_ff.latest)
    else $error("result not loaded in continuous mode");
  lift_a: assert property (!r_ff.rdy_n && bit_ev && !cev |=> r_ff.rdy_n)
    else $error("ready not lifted by serial clock");
  timeout_a: assert property (cev && !byte_ev && !bit_ev && !r_ff.cs_s2 && r_ff.idle_cnt == IDLE_CONV - 7'h01
                              |=> r_ff.tmo_p)
    else $error("framing watchdog missed");
  nop_a: assert property (byte_ev && r_ff.state == ST_IDLE && b == OP_NOP
                          |=> $stable(r_ff.sleep_pend) && r_ff.state == ST_IDLE && r_ff.cal_p == 3'h0)
    else $error("no-op had an effect");

  sync_c: cover property (r_ff.sync_p);
  write_c: cover property (r_ff.wr_p ##[1:200] r_ff.wr_p);
  sleep_wake_c: cover property ($rose(r_ff.pd) ##[1:1000] $fell(r_ff.pd));
  hold_c: cover property ($fell(cfg_reset));

endmodule : acd_core

`default_nettype wire

// ===== verif/acd_host_model.sv
// Host side model that masters the serial link of the command decoder
`default_nettype none

module acd_host_model (
  output var logic sclk,
  output var logic cs_n,
  output var logic din,
  input wire logic dout
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din = 1'b1;
  end

  // Select stays low for the whole session, sleep included
  task automatic select();
    cs_n = 1'b0;
  endtask : select

  // One whole byte, MSB first; clock stands low between bytes
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      #62.5 sclk = 1'b1;
      #10 din = tx[i];
      #52.5 rx[i] = dout;
      sclk = 1'b0;
    end
    #62.5 din = ~din;
  endtask : xfer

endmodule : acd_host_model

`default_nettype wire

// ===== verif/acd_core_tb_top.sv
// Self-checking bench of the serial command decoder
`default_nettype none

module acd_core_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import acd_pkg::*;

  // ****************************************
  // Signals and monitors
  // ****************************************
  logic ref_clk, rst, start, conv_done, sclk, cs_n, din, dout, dout_oe, conversion_ready_n, power_down;
  logic cont_read_mode, filter_reset, cfg_reset, sync_start, reg_wr_en;
  logic system_offset_cal_cmd, system_gain_cal_cmd, internal_offset_cal_cmd;
  logic signed [RAW_W-1:0] conv_raw;
  logic [7:0] reg_rd_data, rd_key, reg_wr_data;
  logic [3:0] reg_addr;
  logic [31:0] seed;
  logic [11:0] wlog [2];
  int cnt [6] = '{default: 0};
  int miscompares = 0;
  int comparisons = 0;
  logic signed [RAW_W-1:0] corner [5] = '{26'h0800000, 26'h07fffff, 26'h3800000, 26'h37fffff, 26'h3ffffff};

  assign reg_rd_data = {4'h5, reg_addr} ^ rd_key;

  always @(posedge ref_clk) begin
    if (!rst) begin
      cnt[0] += int'(system_offset_cal_cmd);
      cnt[1] += int'(system_gain_cal_cmd);
      cnt[2] += int'(internal_offset_cal_cmd);
      cnt[3] += int'(sync_start);
      cnt[5] += int'(cfg_reset);
      if (reg_wr_en === 1'b1) begin
        wlog[cnt[4] % 2] = {reg_addr, reg_wr_data};
        cnt[4]++;
      end
    end
  end

  acd_core #(.RST_HOLD(20)) dut (.ref_clk(ref_clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .din(din),
    .start(start), .conv_done(conv_done), .conv_raw(conv_raw), .reg_rd_data(reg_rd_data), .dout(dout),
    .dout_oe(dout_oe), .conversion_ready_n(conversion_ready_n), .power_down(power_down),
    .cont_read_mode(cont_read_mode), .filter_reset(filter_reset), .cfg_reset(cfg_reset),
    .sync_start(sync_start), .system_offset_cal_cmd(system_offset_cal_cmd),
    .system_gain_cal_cmd(system_gain_cal_cmd), .internal_offset_cal_cmd(internal_offset_cal_cmd),
    .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data));

  acd_host_model host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic logic [23:0] clip(input logic signed [RAW_W-1:0] v);
    if (v > $signed(26'h07fffff)) return 24'h7fffff;
    if (v < $signed(26'h3800000)) return 24'h800000;
    return v[23:0];
  endfunction : clip

  task automatic chk_bit(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %b, seen %b", what, exp, got);
    end
  endtask : chk_bit

  task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk_val

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc

  task automatic cmd(input logic [7:0] b);
    logic [7:0] r;
    host.xfer(b, r);
    cyc(6);
  endtask : cmd

  // Spare byte lets the load cross, then three whole bytes
  task automatic read_word(input logic [7:0] last, output logic [23:0] w);
    logic [7:0] r;
    cmd(OP_NOP);
    for (int i = 2; i >= 0; i--) begin
      host.xfer(i == 0 ? last : OP_NOP, r);
      w[i*8 +: 8] = r;
    end
    cyc(6);
  endtask : read_word

  task automatic convert(input logic signed [RAW_W-1:0] v);
    @(posedge ref_clk);
    conv_raw <= v;
    conv_done <= 1'b1;
    @(posedge ref_clk);
    conv_done <= 1'b0;
    cyc(3);
  endtask : convert

  task automatic end_of_test();
    $display("comparisons %0d, miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_of_test

  // ****************************************
  // Stimulus
  // ****************************************
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  initial begin
    #3000000;
    miscompares++;
    end_of_test();
  end

  initial begin
    logic [23:0] w;
    logic [31:0] t;
    logic [7:0] r;
    logic signed [RAW_W-1:0] v;
    int n0;
    rst = 1'b1;
    start = 1'b1;
    conv_done = 1'b0;
    conv_raw = '0;
    rd_key = 8'h00;
    seed = 32'hfed5;
    cyc(16);
    @(posedge ref_clk) rst <= 1'b0;
    cyc(4);
    chk_bit("cont_read_mode", 1'b1, cont_read_mode);
    chk_bit("power_down", 1'b0, power_down);
    chk_bit("conversion_ready_n", 1'b1, conversion_ready_n);
    chk_bit("dout_oe", 1'b0, dout_oe);
    host.select();
    cyc(1);
    chk_bit("dout_oe", 1'b1, dout_oe);
    $display("test reset values done");
    for (int i = 0; i < 12; i++) begin
      t = rnd();
      v = i < 5 ? corner[i] : t[RAW_W-1:0];
      convert(v);
      chk_bit("conversion_ready_n", 1'b0, conversion_ready_n);
      read_word(OP_NOP, w);
      chk_val("result", {8'h00, clip(v)}, {8'h00, w});
      chk_bit("conversion_ready_n", 1'b1, conversion_ready_n);
    end
    $display("test continuous readout done");
    cmd(OP_STOP_CONTINUOUS_READ_CMD);
    chk_bit("cont_read_mode", 1'b1, cont_read_mode);
    t = rnd();
    v = t[RAW_W-1:0];
    convert(v);
    chk_bit("cont_read_mode", 1'b0, cont_read_mode);
    cmd(OP_RDATA);
    read_word(OP_RDATA, w);
    chk_val("read once", {8'h00, clip(v)}, {8'h00, w});
    read_word(OP_NOP, w);
    chk_val("back to back read", {8'h00, clip(v)}, {8'h00, w});
    $display("test read once done");
    cmd(OP_CONTINUOUS_READ_CMD);
    chk_bit("cont_read_mode", 1'b0, cont_read_mode);
    t = rnd();
    v = t[RAW_W-1:0];
    convert(v);
    chk_bit("cont_read_mode", 1'b1, cont_read_mode);
    read_word(OP_NOP, w);
    chk_val("result after mode change", {8'h00, clip(v)}, {8'h00, w});
    cmd(OP_STOP_CONTINUOUS_READ_CMD);
    convert(v);
    chk_bit("cont_read_mode", 1'b0, cont_read_mode);
    $display("test mode change done");
    for (int k = 0; k < 3; k++) begin
      n0 = cnt[0] + cnt[1] + cnt[2];
      t = cnt[k];
      cmd(OP_SYSTEM_OFFSET_CAL_CMD + 8'(k));
      chk_val("calibration pulse", t + 1, cnt[k]);
      chk_val("calibration total", n0 + 1, cnt[0] + cnt[1] + cnt[2]);
    end
    cmd(OP_SYNC);
    cmd(OP_SYNC | 8'h01);
    chk_val("sync pulses", 1, cnt[3]);
    n0 = cnt[0] + cnt[1] + cnt[2] + cnt[3] + cnt[4];
    cmd(8'h08);
    cmd(OP_NOP);
    chk_val("pulses after idle codes", n0, cnt[0] + cnt[1] + cnt[2] + cnt[3] + cnt[4]);
    chk_bit("cont_read_mode", 1'b0, cont_read_mode);
    $display("test command codes done");
    cmd(OP_SLEEP);
    chk_bit("power_down", 1'b0, power_down);
    convert(v);
    chk_bit("power_down", 1'b1, power_down);
    n0 = cnt[0];
    cmd(OP_SYSTEM_OFFSET_CAL_CMD);
    chk_val("calibration while asleep", n0, cnt[0]);
    @(posedge ref_clk) start <= 1'b0;
    cyc(4);
    cmd(OP_WAKEUP);
    chk_bit("power_down", 1'b1, power_down);
    @(posedge ref_clk) start <= 1'b1;
    cyc(4);
    cmd(OP_WAKEUP | 8'h01);
    chk_bit("power_down", 1'b0, power_down);
    $display("test power down done");
    cmd(OP_RESET);
    chk_bit("cfg_reset", 1'b1, cfg_reset);
    chk_bit("filter_reset", 1'b1, filter_reset);
    for (int i = 0; i < 200 && cfg_reset === 1'b1; i++) cyc(1);
    if (cfg_reset !== 1'b0) begin
      miscompares++;
      end_of_test();
    end
    chk_val("reset hold cycles", 20, cnt[5]);
    chk_bit("cont_read_mode", 1'b1, cont_read_mode);
    $display("test soft reset done");
    t = rnd();
    cmd(8'h43);
    cmd(8'h01);
    cmd(t[7:0]);
    cmd(t[15:8]);
    chk_val("write log", {8'h00, 4'h3, t[7:0], 4'h4, t[15:8]}, {8'h00, wlog[0], wlog[1]});
    chk_val("write count", 2, cnt[4]);
    @(posedge ref_clk) rd_key <= t[23:16];
    cmd(8'h2a);
    cmd(8'h00);
    cmd(OP_NOP);
    host.xfer(OP_NOP, r);
    chk_val("register data", {24'h000000, 8'h5a ^ t[23:16]}, {24'h000000, r});
    $display("test register access done");
    // Half-finished write command is abandoned by the idle timeout
    cmd(8'h43);
    for (int i = 0; i < 64; i++) convert(v);
    n0 = cnt[0];
    cmd(OP_SYSTEM_OFFSET_CAL_CMD);
    chk_val("calibration after idle timeout", n0 + 1, cnt[0]);
    $display("test idle timeout done");
    end_of_test();
  end

endmodule : acd_core_tb_top

`default_nettype wire
